// >>> cbcfg_consts.svh
// Offsets, field positions, reset values and sizes for the clock buffer configuration bytes
`ifndef CBCFG_CONSTS_SVH
`define CBCFG_CONSTS_SVH

// ==========================================================================
// Byte locations
`define CBCFG_OFS_PLL_AMP      8'h01
`define CBCFG_OFS_SLEW         8'h02
`define CBCFG_OFS_FREQ         8'h03
`define CBCFG_OFS_RSVD4        8'h04
`define CBCFG_OFS_REV_VEND     8'h05
`define CBCFG_OFS_DEV_TYPE     8'h06
`define CBCFG_OFS_RSVD7        8'h07

// ==========================================================================
// Field positions
`define CBCFG_B1_RB_HI         7
`define CBCFG_B1_RB_LO         6
`define CBCFG_B1_SW_EN         5
`define CBCFG_B1_SEL_HI        4
`define CBCFG_B1_SEL_LO        3
`define CBCFG_B1_RSVD          2
`define CBCFG_B1_SWING_HI      1
`define CBCFG_B1_SWING_LO      0
`define CBCFG_B3_FREQ_EN       5
`define CBCFG_B3_FREQ_HI       4
`define CBCFG_B3_FREQ_LO       3
`define CBCFG_B3_FB_SLEW       0

// ==========================================================================
// Power-up values
`define CBCFG_RST_SW_EN        1'b0
`define CBCFG_RST_SW_SEL       2'h0
`define CBCFG_RST_SWING        2'h2
`define CBCFG_RST_SLEW         8'hFF
`define CBCFG_RST_FREQ_EN      1'b0
`define CBCFG_RST_FREQ_SEL     2'h0
`define CBCFG_RST_FB_SLEW      1'b1
`define CBCFG_RST_RSVD_BIT     1'b1
`define CBCFG_RST_RSVD4        8'hFF
`define CBCFG_RST_B3_RSVD      8'hFF
`define CBCFG_RST_RSVD7        8'h08
`define CBCFG_ZERO_BYTE        8'h00

// ==========================================================================
// Block transfer
`define CBCFG_CNT_ONE          8'h01
`define CBCFG_LOC_ONE          8'h01

`endif

// >>> cbcfg_host.sv
// Bus engine model issuing block writes and reads
`timescale 1ns/1ns
`default_nettype none
module cbcfg_host (
  input  wire logic       clk_sys,
  output logic            xferStart,
  output logic            xferWrite,
  output logic [7:0]      xferLoc,
  output logic [7:0]      xferCount,
  output logic            xferStop,
  output logic            wrValid,
  output logic [7:0]      wrData,
  output logic            rdReq,
  input  wire logic       rdValid,
  input  wire logic [7:0] rdData
);
  // ==========================================================================
  // Block transfers
  // Idle levels before the first transfer
  initial begin
    {xferStart, xferWrite, xferStop, wrValid, rdReq, xferLoc, xferCount, wrData} = '0;
  end
  logic [7:0] rxQ[$];
  always @(posedge clk_sys) if (rdValid === 1'b1) rxQ.push_back(rdData);
  task automatic opn(input logic wr, input logic [7:0] loc, input logic [7:0] cnt);
    @(negedge clk_sys);
    xferStart = 1'b1;
    xferWrite = wr;
    xferLoc = loc;
    xferCount = cnt;
    @(negedge clk_sys);
    xferStart = 1'b0;
    xferLoc = ~loc;
  endtask : opn
  // Stop for one cycle then one idle cycle; opn waits one more idle cycle before the next start
  task automatic shut();
    xferStop = 1'b1;
    @(negedge clk_sys);
    xferStop = 1'b0;
    @(negedge clk_sys);
  endtask : shut
  task automatic blkWrite(input logic [7:0] loc, input logic [7:0] cnt, input logic [7:0] b[9]);
    opn(1'b1, loc, cnt);
    for (int i = 0; i < cnt; i++) begin
      wrValid = 1'b1;
      wrData = b[i];
      @(negedge clk_sys);
    end
    wrValid = 1'b0;
    wrData = ~wrData;
    shut();
  endtask : blkWrite
  task automatic blkRead(input logic [7:0] loc, input logic [7:0] cnt);
    rxQ.delete();
    opn(1'b0, loc, cnt);
    repeat (cnt) begin
      rdReq = 1'b1;
      @(negedge clk_sys);
    end
    rdReq = 1'b0;
    shut();
  endtask : blkRead
endmodule : cbcfg_host
`default_nettype wire

// >>> cbcfg_pkg.sv
// Types shared by the clock buffer configuration register bank
`default_nettype none
package cbcfg_pkg;

  typedef enum logic [1:0] {
    CBCFG_ST_IDLE,
    CBCFG_ST_WRITE,
    CBCFG_ST_READ
  } cbcfg_xfer_e;

  typedef struct packed {
    cbcfg_xfer_e xfer;
    logic [7:0]  loc;
    logic [7:0]  remain;
    logic [7:0]  rdData;
    logic        rdValid;
    logic        swOverrideEn;
    logic [1:0]  swModeSel;
    logic [1:0]  swingSel;
    logic [7:0]  edgeSpeed;
    logic        freqSelEn;
    logic [1:0]  freqChoice;
    logic        feedbackEdgeSpeed;
    logic [1:0]  strapMode;
    logic        strapTaken;
  } cbcfg_state_s;

endpackage : cbcfg_pkg
`default_nettype wire

// >>> cbcfg_regs.sv
// Configuration and identification bytes 1 to 7 behind the serial management bus engine
// ==========================================================================
// What this block does
// - Byte 1 bits 7:6 read back PLL mode latched from strap at power-up.
// - Byte 1 bit 5 picks mode source: 0 strap bits, 1 software bits 4:3.
// - Software PLL mode bits reset to 0, ignored unless byte 1 bit 5 set.
// - Byte 1 bits 1:0 select output swing, power-up value 10.
// - Byte 2 bit n sets output n slew, 1 fast, resets all ones.
// - Byte 3 bit 5 enables software frequency select, resets to 0.
// - Byte 3 bits 4:3 frequency select reset 0, ignored unless bit 5 set.
// - Byte 3 bit 0 sets feedback slew, 1 fast, power-up value 1.
// - Byte 5 read-only: revision code high nibble, vendor code low nibble.
// - Byte 6 read-only: device type bits 7:6, device identifier bits 5:0.
// - Host uses block write/read with start location and count, may stop anytime.
`timescale 1ns/1ns
`default_nettype none
`include "cbcfg_consts.svh"

module cbcfg_regs #(
  parameter logic [3:0] REVISION_CODE = 4'h1, // Arbitrary value
  parameter logic [3:0] VENDOR_CODE   = 4'h5, // Arbitrary value
  parameter logic [1:0] PART_CATEGORY = 2'h1, // 01 zero-delay buffer
  parameter logic [5:0] PART_CODE     = 6'h2A // Arbitrary value
) (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic [1:0] pllStrapMode,
  input  wire logic       xferStart,
  input  wire logic       xferWrite,
  input  wire logic [7:0] xferLoc,
  input  wire logic [7:0] xferCount,
  input  wire logic       xferStop,
  input  wire logic       wrValid,
  input  wire logic [7:0] wrData,
  output logic            wrReady,
  input  wire logic       rdReq,
  output logic            rdValid,
  output logic [7:0]      rdData,
  output logic            xferBusy,
  output logic [1:0]      pllModeEff,
  output logic [1:0]      swingSel,
  output logic [7:0]      edgeSpeed,
  output logic            freqSelEn,
  output logic [1:0]      freqChoice,
  output logic            feedbackEdgeSpeed
);

  cbcfg_pkg::cbcfg_state_s st_q;
  cbcfg_pkg::cbcfg_state_s st_d;
  logic                    startTake;
  logic                    xferEnd;
  logic                    wrTake;
  logic                    rdTake;

  // ==========================================================================
  // Transfer events
  // A stop or an exhausted count closes the transfer before any further byte is taken
  assign startTake = xferStart && st_q.strapTaken && (st_q.xfer == cbcfg_pkg::CBCFG_ST_IDLE);
  assign xferEnd   = xferStop || (st_q.remain == `CBCFG_ZERO_BYTE);
  assign wrTake    = wrValid && !xferEnd && (st_q.xfer == cbcfg_pkg::CBCFG_ST_WRITE);
  assign rdTake    = rdReq && !xferEnd && (st_q.xfer == cbcfg_pkg::CBCFG_ST_READ);

  // ==========================================================================
  // Byte 1 and byte 3 images
  // Readback shows the latched strap, not the effective mode
  function automatic logic [7:0] modeImage(input cbcfg_pkg::cbcfg_state_s s);
    logic [7:0] b;
    b                                        = `CBCFG_ZERO_BYTE;
    b[`CBCFG_B1_RB_HI:`CBCFG_B1_RB_LO]       = s.strapMode;
    b[`CBCFG_B1_SW_EN]                       = s.swOverrideEn;
    b[`CBCFG_B1_SEL_HI:`CBCFG_B1_SEL_LO]     = s.swModeSel;
    b[`CBCFG_B1_RSVD]                        = `CBCFG_RST_RSVD_BIT;
    b[`CBCFG_B1_SWING_HI:`CBCFG_B1_SWING_LO] = s.swingSel;
    return b;
  endfunction : modeImage

  // Stored frequency bits show even while the enable is off
  function automatic logic [7:0] freqImage(input cbcfg_pkg::cbcfg_state_s s);
    logic [7:0] b;
    b                                      = `CBCFG_RST_B3_RSVD;
    b[`CBCFG_B3_FREQ_EN]                   = s.freqSelEn;
    b[`CBCFG_B3_FREQ_HI:`CBCFG_B3_FREQ_LO] = s.freqChoice;
    b[`CBCFG_B3_FB_SLEW]                   = s.feedbackEdgeSpeed;
    return b;
  endfunction : freqImage

  // ==========================================================================
  // Write decode: only writable fields take the byte
  function automatic cbcfg_pkg::cbcfg_state_s writeByte(
    input cbcfg_pkg::cbcfg_state_s s,
    input logic [7:0]              loc,
    input logic [7:0]              d
  );
    cbcfg_pkg::cbcfg_state_s n;
    n = s;
    if (loc == `CBCFG_OFS_PLL_AMP) begin
      n.swOverrideEn = d[`CBCFG_B1_SW_EN];
      n.swModeSel    = d[`CBCFG_B1_SEL_HI:`CBCFG_B1_SEL_LO];
      n.swingSel     = d[`CBCFG_B1_SWING_HI:`CBCFG_B1_SWING_LO];
    end else if (loc == `CBCFG_OFS_SLEW) begin
      n.edgeSpeed = d;
    end else if (loc == `CBCFG_OFS_FREQ) begin
      n.freqSelEn         = d[`CBCFG_B3_FREQ_EN];
      n.freqChoice        = d[`CBCFG_B3_FREQ_HI:`CBCFG_B3_FREQ_LO];
      n.feedbackEdgeSpeed = d[`CBCFG_B3_FB_SLEW];
    end
    // Readback, identity and reserved bits are never stored, so writes there change nothing
    return n;
  endfunction : writeByte

  // ==========================================================================
  // Read decode, shared by read path
  function automatic logic [7:0] readByte(input cbcfg_pkg::cbcfg_state_s s, input logic [7:0] loc);
    logic [7:0] b;
    b = `CBCFG_ZERO_BYTE;
    if (loc == `CBCFG_OFS_PLL_AMP) begin
      b = modeImage(s);
    end else if (loc == `CBCFG_OFS_SLEW) begin
      b = s.edgeSpeed;
    end else if (loc == `CBCFG_OFS_FREQ) begin
      b = freqImage(s);
    end else if (loc == `CBCFG_OFS_RSVD4) begin
      b = `CBCFG_RST_RSVD4;
    end else if (loc == `CBCFG_OFS_REV_VEND) begin
      b = {REVISION_CODE, VENDOR_CODE};
    end else if (loc == `CBCFG_OFS_DEV_TYPE) begin
      b = {PART_CATEGORY, PART_CODE};
    end else if (loc == `CBCFG_OFS_RSVD7) begin
      b = `CBCFG_RST_RSVD7;
    end
    return b;
  endfunction : readByte

  // ==========================================================================
  // Next state
  always_comb begin
    st_d         = st_q;
    st_d.rdValid = 1'b0;
    // Strap is caught on the first clock after reset release, never under reset itself
    if (!st_q.strapTaken) begin
      st_d.strapMode  = pllStrapMode;
      st_d.strapTaken = 1'b1;
    end
    case (st_q.xfer)
      cbcfg_pkg::CBCFG_ST_IDLE: begin
        if (startTake) begin
          st_d.loc    = xferLoc;
          st_d.remain = xferCount;
          st_d.xfer   = xferWrite ? cbcfg_pkg::CBCFG_ST_WRITE : cbcfg_pkg::CBCFG_ST_READ;
        end
      end
      cbcfg_pkg::CBCFG_ST_WRITE: begin
        if (xferEnd) begin
          st_d.xfer = cbcfg_pkg::CBCFG_ST_IDLE;
        end else if (wrTake) begin
          st_d        = writeByte(st_d, st_q.loc, wrData);
          st_d.loc    = 8'(st_q.loc + `CBCFG_LOC_ONE);
          st_d.remain = 8'(st_q.remain - `CBCFG_CNT_ONE);
        end
      end
      cbcfg_pkg::CBCFG_ST_READ: begin
        if (xferEnd) begin
          st_d.xfer = cbcfg_pkg::CBCFG_ST_IDLE;
        end else if (rdTake) begin
          st_d.rdData  = readByte(st_q, st_q.loc);
          st_d.rdValid = 1'b1;
          st_d.loc     = 8'(st_q.loc + `CBCFG_LOC_ONE);
          st_d.remain  = 8'(st_q.remain - `CBCFG_CNT_ONE);
        end
      end
      default: begin
        st_d.xfer = cbcfg_pkg::CBCFG_ST_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_q.xfer              <= cbcfg_pkg::CBCFG_ST_IDLE;
      st_q.loc               <= `CBCFG_ZERO_BYTE;
      st_q.remain            <= `CBCFG_ZERO_BYTE;
      st_q.rdData            <= `CBCFG_ZERO_BYTE;
      st_q.rdValid           <= 1'b0;
      st_q.swOverrideEn      <= `CBCFG_RST_SW_EN;
      st_q.swModeSel         <= `CBCFG_RST_SW_SEL;
      st_q.swingSel          <= `CBCFG_RST_SWING;
      st_q.edgeSpeed         <= `CBCFG_RST_SLEW;
      st_q.freqSelEn         <= `CBCFG_RST_FREQ_EN;
      st_q.freqChoice        <= `CBCFG_RST_FREQ_SEL;
      st_q.feedbackEdgeSpeed <= `CBCFG_RST_FB_SLEW;
      st_q.strapMode         <= `CBCFG_RST_SW_SEL;
      st_q.strapTaken        <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // Bus-side outputs
  assign wrReady  = (st_q.xfer == cbcfg_pkg::CBCFG_ST_WRITE) && (st_q.remain != `CBCFG_ZERO_BYTE);
  assign rdValid  = st_q.rdValid;
  assign rdData   = st_q.rdData;
  assign xferBusy = (st_q.xfer != cbcfg_pkg::CBCFG_ST_IDLE) || !st_q.strapTaken;

  // ==========================================================================
  // Configuration outputs toward the PLL and output drivers
  // Software mode bits reach the PLL only when the override is on
  assign pllModeEff        = st_q.swOverrideEn ? st_q.swModeSel : st_q.strapMode;
  assign swingSel          = st_q.swingSel;
  // One slew bit per differential output, bit n to output n
  generate
    for (genvar gOut = 0; gOut < $bits(edgeSpeed); gOut++) begin : g_slew
      assign edgeSpeed[gOut] = st_q.edgeSpeed[gOut];
    end
  endgenerate
  assign freqSelEn         = st_q.freqSelEn;
  // Gated to zero while disabled so downstream uses its non-software source
  assign freqChoice        = st_q.freqSelEn ? st_q.freqChoice : `CBCFG_RST_FREQ_SEL;
  assign feedbackEdgeSpeed = st_q.feedbackEdgeSpeed;

endmodule : cbcfg_regs
`default_nettype wire

// >>> cbcfg_regs_chk.sv
// Port-level checks for the configuration byte bank
`timescale 1ns/1ns
`default_nettype none
module cbcfg_regs_chk (
  input wire logic       clk_sys,
  input wire logic       nrst,
  input wire logic       xferStart,
  input wire logic       xferStop,
  input wire logic       wrValid,
  input wire logic       rdReq,
  input wire logic       wrReady,
  input wire logic       rdValid,
  input wire logic [7:0] rdData,
  input wire logic       xferBusy,
  input wire logic [1:0] swingSel,
  input wire logic [7:0] edgeSpeed,
  input wire logic       freqSelEn,
  input wire logic [1:0] freqChoice,
  input wire logic       feedbackEdgeSpeed
);
  // ==========================================================================
  // Handshake and field relations
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_idleStart; !xferBusy && xferStart; endsequence
  sequence s_stop; xferBusy && xferStop; endsequence
  property p_startBusy; s_idleStart |=> xferBusy; endproperty
  a_startBusy: assert property (p_startBusy) else $error("no busy after start");
  property p_stopIdle; s_stop |=> !xferBusy; endproperty
  a_stopIdle: assert property (p_stopIdle) else $error("busy after stop");
  property p_rdAfterReq; rdValid |-> $past(rdReq && xferBusy); endproperty
  a_rdAfterReq: assert property (p_rdAfterReq) else $error("read byte without request");
  property p_rdHold; !rdValid |-> $stable(rdData); endproperty
  a_rdHold: assert property (p_rdHold) else $error("read byte moved");
  property p_wrReady; wrReady |-> xferBusy; endproperty
  a_wrReady: assert property (p_wrReady) else $error("ready while idle");
  property p_freqGate; !freqSelEn |-> freqChoice == 2'h0; endproperty
  a_freqGate: assert property (p_freqGate) else $error("frequency choice leaks");
  // Fields move only in answer to a write byte
  property p_swingCause; $changed(swingSel) |-> $past(wrValid) || $past(wrValid, 2); endproperty
  a_swingCause: assert property (p_swingCause) else $error("swing moved alone");
  property p_slewCause; $changed(edgeSpeed) |-> $past(wrValid) || $past(wrValid, 2); endproperty
  a_slewCause: assert property (p_slewCause) else $error("slew moved alone");
  property p_fbCause; $changed(feedbackEdgeSpeed) |-> $past(wrValid) || $past(wrValid, 2); endproperty
  a_fbCause: assert property (p_fbCause) else $error("feedback slew moved alone");
endmodule : cbcfg_regs_chk
bind cbcfg_regs cbcfg_regs_chk u_chk (.clk_sys, .nrst, .xferStart, .xferStop, .wrValid, .rdReq, .wrReady,
  .rdValid, .rdData, .xferBusy, .swingSel, .edgeSpeed, .freqSelEn, .freqChoice, .feedbackEdgeSpeed);
`default_nettype wire

// >>> clock_buffer_config_bytes_tb.sv
// Self-checking bench for the configuration byte bank
`timescale 1ns/1ns
`default_nettype none
module clock_buffer_config_bytes_tb;
  logic clk_sys, nrst, wrReady, rdValid, xferBusy, freqSelEn, feedbackEdgeSpeed;
  logic xferStart, xferWrite, xferStop, wrValid, rdReq;
  logic [1:0] strap, pllModeEff, swingSel, freqChoice;
  logic [7:0] xferLoc, xferCount, wrData, rdData, edgeSpeed, loc, cnt;
  logic [7:0] expB[9];
  logic [7:0] bytes[9];
  int mismatches, n_tests;
  // Identity codes given here are arbitrary
  cbcfg_regs #(.REVISION_CODE(4'h6), .VENDOR_CODE(4'hA), .PART_CATEGORY(2'h1), .PART_CODE(6'h15)) DUT (
    .clk_sys, .nrst, .pllStrapMode(strap), .xferStart, .xferWrite, .xferLoc, .xferCount,
    .xferStop, .wrValid, .wrData, .wrReady, .rdReq, .rdValid, .rdData, .xferBusy, .pllModeEff,
    .swingSel, .edgeSpeed, .freqSelEn, .freqChoice, .feedbackEdgeSpeed);
  cbcfg_host host (.clk_sys, .xferStart, .xferWrite, .xferLoc, .xferCount, .xferStop, .wrValid,
    .wrData, .rdReq, .rdValid, .rdData);
  // ==========================================================================
  // Expectations
  function automatic logic [7:0] wmask(int i);
    case (i) 1: return 8'h3B; 2: return 8'hFF; 3: return 8'h39; default: return 8'h00; endcase
  endfunction : wmask
  // Identity bytes follow the codes given to the instance above
  function automatic logic [7:0] rstImg(int i);
    case (i) 1: return {strap, 6'h06}; 2, 4: return 8'hFF; 3: return 8'hC7; 5: return 8'h6A;
      6: return 8'h55; 7: return 8'h08; default: return 8'h00; endcase
  endfunction : rstImg
  function automatic logic [15:0] outExp();
    return {expB[1][5] ? expB[1][4:3] : strap, expB[1][1:0], expB[3][5],
      expB[3][5] ? expB[3][4:3] : 2'h0, expB[3][0], expB[2]};
  endfunction : outExp
  task automatic cmpByte(input int i, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value byte %0d expected %h seen %h", i, e, g);
    end
  endtask : cmpByte
  task automatic cmpOut(input logic [15:0] e);
    n_tests++;
    if ({pllModeEff, swingSel, freqSelEn, freqChoice, feedbackEdgeSpeed, edgeSpeed} !== e) begin
      mismatches++;
      $display("wrong value outputs expected %h seen %h", e, {pllModeEff, swingSel, freqSelEn,
        freqChoice, feedbackEdgeSpeed, edgeSpeed});
    end
  endtask : cmpOut
  task automatic doReset();
    nrst = 1'b0;
    strap = 2'($urandom);
    repeat (12) @(negedge clk_sys);
    nrst = 1'b1;
    for (int i = 0; i < 9; i++) expB[i] = rstImg(i);
    repeat (2) @(negedge clk_sys);
  endtask : doReset
  task automatic readAll();
    host.blkRead(8'h00, 8'h09);
    for (int i = 0; i < 9; i++) cmpByte(i, expB[i], host.rxQ[i]);
  endtask : readAll
  task automatic tally_and_finish();
    $display("mismatches %0d tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  // ==========================================================================
  // Stimulus
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    #2000000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'h880D5D63));
    mismatches = 0;
    n_tests = 0;
    doReset();
    cmpOut(outExp());
    readAll();
    for (int k = 0; k < 10; k++) begin
      loc = (k < 2) ? 8'h00 : 8'($urandom_range(0, 7));
      cnt = (k < 2) ? 8'h09 : 8'($urandom_range(1, 9 - loc));
      // First all ones, then selector bits without their enables
      for (int j = 0; j < 9; j++) bytes[j] = (k == 0) ? 8'hFF : (k == 1) ? 8'h18 : 8'($urandom);
      host.blkWrite(loc, cnt, bytes);
      for (int j = 0; j < cnt; j++) expB[loc + j] = (expB[loc + j] & ~wmask(loc + j)) | (bytes[j] & wmask(loc + j));
      cmpOut(outExp());
      readAll();
      if (k == 5) doReset();
      if (k == 5) cmpOut(outExp());
    end
    tally_and_finish();
  end
endmodule : clock_buffer_config_bytes_tb
`default_nettype wire
